/* File: hw/ifsl_top.sv */
// instruction fault status logger with AHB-Lite register slave and interrupt
// Functional notes
// - a translation buffer error logs the failing buffer in bits 63:62, 00 full, 10 set associative.
// - coinciding buffer errors log full parity, then set parity, then set multi-hit, then full multi-hit.
// - the failing entry index goes to bits 59:49; on multi-hit any matching index may be shown.
// - bit 46 is set whenever the uncorrectable error bit is set.
// - the error mark tag is captured in bits 45:32 when a marked uncorrectable error is logged.
// - bit 31 is set on an uncorrectable error in a fetched instruction word.
// - bit 30 is set when a fetch returned a bus error reply.
// - bit 29 is set when a fetch returned a bus timeout reply.
// - a lookup error sets bit 27 for multi-hit and bit 26 for parity.
// - bit 25 records a noncacheable faulting reference.
// - the 8-bit space id of the faulting reference goes to bits 23:16.
// - the space id is 80 hex at trap depth zero and 04 hex above zero.
// - the fault valid flag is set on an exception but not on a plain miss.
// - the overwrite flag is set when a new exception finds fault valid still set.
// - the register is updated by software writes and otherwise only on a miss, an access exception or an access error trap.
`timescale 1ns/10ps
`include "ifsl_defines.svh"
module ifsl_top #(
  parameter int IDX_W = 11,
  parameter int EID_W = 14,
  parameter int DEPTH_W = 3
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  input wire logic trap_valid,
  input wire ifsl_pkg::ifsl_kind_t trap_kind,
  input wire logic [DEPTH_W-1:0] trap_depth,
  input wire logic fa_parity_err,
  input wire logic sa_parity_err,
  input wire logic sa_multihit_err,
  input wire logic fa_multihit_err,
  input wire logic [IDX_W-1:0] fa_parity_idx,
  input wire logic [IDX_W-1:0] sa_parity_idx,
  input wire logic [IDX_W-1:0] sa_multihit_idx,
  input wire logic [IDX_W-1:0] fa_multihit_idx,
  input wire logic uncorrectable_fetch_error,
  input wire logic [EID_W-1:0] err_mark_tag,
  input wire logic bus_error_reply,
  input wire logic bus_timeout_reply,
  input wire logic noncacheable
);

  ////////////////////////////////////////////////////////////////////////////
  // register address decode, shared by write and read paths
  function automatic ifsl_pkg::ifsl_reg_t reg_decode(input logic [31:0] addr);
    logic [7:0] ofs;
    ofs = addr[7:0];
    reg_decode = ifsl_pkg::IFSL_REG_NONE;
    if (addr[31:8] == 24'h00_0000) begin
      case (ofs)
        `IFSL_OFS_IFS_LO: reg_decode = ifsl_pkg::IFSL_REG_IFS_LO;
        `IFSL_OFS_IFS_HI: reg_decode = ifsl_pkg::IFSL_REG_IFS_HI;
        `IFSL_OFS_DFS_LO: reg_decode = ifsl_pkg::IFSL_REG_DFS_LO;
        `IFSL_OFS_DFS_HI: reg_decode = ifsl_pkg::IFSL_REG_DFS_HI;
        `IFSL_OFS_IRQ_STAT: reg_decode = ifsl_pkg::IFSL_REG_IRQ_STAT;
        `IFSL_OFS_IRQ_MASK: reg_decode = ifsl_pkg::IFSL_REG_IRQ_MASK;
        default: reg_decode = ifsl_pkg::IFSL_REG_NONE;
      endcase
    end
  endfunction : reg_decode

  ////////////////////////////////////////////////////////////////////////////
  // translation buffer error pick
  logic tlb_any;
  ifsl_pkg::ifsl_buf_t tlb_buf;
  logic [IDX_W-1:0] tlb_idx;
  logic tlb_mhit;
  logic tlb_par;

  ifsl_tlb_pick #(.IDX_W(IDX_W)) u_pick (
    .fa_parity_err(fa_parity_err),
    .sa_parity_err(sa_parity_err),
    .sa_multihit_err(sa_multihit_err),
    .fa_multihit_err(fa_multihit_err),
    .fa_parity_idx(fa_parity_idx),
    .sa_parity_idx(sa_parity_idx),
    .sa_multihit_idx(sa_multihit_idx),
    .fa_multihit_idx(fa_multihit_idx),
    .any_err(tlb_any),
    .buf_sel(tlb_buf),
    .idx(tlb_idx),
    .multihit(tlb_mhit),
    .parity(tlb_par)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus slave state
  logic dp_wr_ff, nxt_dp_wr;
  ifsl_pkg::ifsl_reg_t dp_reg_ff, nxt_dp_reg;
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic hreadyout_ff;
  logic hresp_ff;
  logic ap_valid;

  // fault status state
  logic [63:0] ifs_ff, nxt_ifs;
  logic [63:0] dfs_ff, nxt_dfs;
  logic [3:0] ists_ff, nxt_ists;
  logic [3:0] imask_ff, nxt_imask;
  logic irq_ff, nxt_irq;
  logic [3:0] evt;
  logic cur_fv;
  logic [7:0] space_id;

  assign ap_valid = hsel && htrans[1] && hready;
  assign space_id = (trap_depth == '0) ? `IFSL_PRIMARY_SPACE_CODE : `IFSL_NUCLEUS_SPACE_CODE;

  ////////////////////////////////////////////////////////////////////////////
  // register next values: software write first, hardware logging on top
  always_comb begin
    logic [63:0] tmp;
    tmp = ifs_ff;
    nxt_dfs = dfs_ff;
    nxt_imask = imask_ff;
    nxt_ists = ists_ff;
    evt = 4'h0;
    if (dp_wr_ff) begin
      unique case (dp_reg_ff)
        ifsl_pkg::IFSL_REG_IFS_LO: tmp[31:0] = hwdata;
        ifsl_pkg::IFSL_REG_IFS_HI: tmp[63:32] = hwdata;
        ifsl_pkg::IFSL_REG_DFS_LO: nxt_dfs[31:0] = hwdata;
        ifsl_pkg::IFSL_REG_DFS_HI: nxt_dfs[63:32] = hwdata;
        ifsl_pkg::IFSL_REG_IRQ_STAT: nxt_ists = ists_ff & ~hwdata[3:0];
        ifsl_pkg::IFSL_REG_IRQ_MASK: nxt_imask = hwdata[3:0];
        ifsl_pkg::IFSL_REG_NONE: tmp = tmp;
      endcase
    end
    cur_fv = tmp[`IFSL_FV];
    // only the three trap kinds touch the register
    if (trap_valid) begin
      unique case (trap_kind)
        ifsl_pkg::IFSL_KIND_MISS: begin
          tmp[`IFSL_TM] = 1'b1;
          // a miss never sets fault valid and always sets bit 15; on a live fault everything else is kept
          if (!cur_fv) begin
            tmp[`IFSL_OW] = 1'b0;
          end
          evt[`IFSL_IRQ_MISS] = 1'b1;
        end
        ifsl_pkg::IFSL_KIND_EXC: begin
          tmp[`IFSL_OW] = cur_fv;
          tmp[`IFSL_FV] = 1'b1;
          tmp[`IFSL_ASI_HI:`IFSL_ASI_LO] = space_id;
          if (!cur_fv) begin
            tmp[`IFSL_TM] = 1'b0;
          end
          evt[`IFSL_IRQ_EXC] = 1'b1;
          evt[`IFSL_IRQ_OVW] = cur_fv;
        end
        ifsl_pkg::IFSL_KIND_ERR: begin
          tmp[`IFSL_OW] = cur_fv;
          tmp[`IFSL_FV] = 1'b1;
          tmp[`IFSL_ASI_HI:`IFSL_ASI_LO] = space_id;
          if (!cur_fv) begin
            tmp[`IFSL_TM] = 1'b0;
          end
          if (tlb_any) begin
            tmp[`IFSL_BUF_HI:`IFSL_BUF_LO] = tlb_buf;
            tmp[`IFSL_IDX_HI:`IFSL_IDX_LO] = tlb_idx;
          end
          tmp[`IFSL_MHIT] = tlb_mhit;
          tmp[`IFSL_PAR] = tlb_par;
          tmp[`IFSL_UE] = uncorrectable_fetch_error;
          // every uncorrectable error counts as marked
          tmp[`IFSL_MK] = uncorrectable_fetch_error;
          if (uncorrectable_fetch_error) begin
            tmp[`IFSL_EID_HI:`IFSL_EID_LO] = err_mark_tag;
          end
          tmp[`IFSL_BUS_ERROR_REPLY] = bus_error_reply;
          tmp[`IFSL_BUS_TIMEOUT_REPLY] = bus_timeout_reply;
          tmp[`IFSL_NC] = noncacheable;
          evt[`IFSL_IRQ_ERR] = 1'b1;
          evt[`IFSL_IRQ_OVW] = cur_fv;
        end
        ifsl_pkg::IFSL_KIND_NONE: tmp = tmp;
      endcase
    end
    nxt_ifs = tmp & `IFSL_IFS_RW_MASK;
    // set wins over a clear in the same cycle
    nxt_ists = nxt_ists | evt;
    nxt_irq = |(nxt_ists & nxt_imask);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ifs_ff <= `IFSL_IFS_RESET;
      dfs_ff <= `IFSL_DFS_RESET;
      ists_ff <= `IFSL_IRQ_RESET;
      imask_ff <= `IFSL_IRQ_RESET;
      irq_ff <= 1'b0;
    end else begin
      ifs_ff <= nxt_ifs;
      dfs_ff <= nxt_dfs;
      ists_ff <= nxt_ists;
      imask_ff <= nxt_imask;
      irq_ff <= nxt_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: zero wait state, read data from next values so a read right
  // after a write to the same word sees the new contents
  always_comb begin
    nxt_dp_wr = ap_valid && hwrite;
    nxt_dp_reg = ap_valid ? reg_decode(haddr) : ifsl_pkg::IFSL_REG_NONE;
    nxt_hrdata = hrdata_ff;
    if (ap_valid && !hwrite) begin
      unique case (reg_decode(haddr))
        ifsl_pkg::IFSL_REG_IFS_LO: nxt_hrdata = nxt_ifs[31:0];
        ifsl_pkg::IFSL_REG_IFS_HI: nxt_hrdata = nxt_ifs[63:32];
        ifsl_pkg::IFSL_REG_DFS_LO: nxt_hrdata = nxt_dfs[31:0];
        ifsl_pkg::IFSL_REG_DFS_HI: nxt_hrdata = nxt_dfs[63:32];
        ifsl_pkg::IFSL_REG_IRQ_STAT: nxt_hrdata = {28'h000_0000, nxt_ists};
        ifsl_pkg::IFSL_REG_IRQ_MASK: nxt_hrdata = {28'h000_0000, nxt_imask};
        ifsl_pkg::IFSL_REG_NONE: nxt_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_ff <= 1'b0;
      dp_reg_ff <= ifsl_pkg::IFSL_REG_NONE;
      hrdata_ff <= 32'h0000_0000;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end else begin
      dp_wr_ff <= nxt_dp_wr;
      dp_reg_ff <= nxt_dp_reg;
      hrdata_ff <= nxt_hrdata;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;
  assign irq = irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic err_evt;
  logic upd_evt;
  assign err_evt = trap_valid && (trap_kind == ifsl_pkg::IFSL_KIND_ERR);
  assign upd_evt = trap_valid && (trap_kind != ifsl_pkg::IFSL_KIND_NONE);

  buf_select_a: assert property (
    err_evt && tlb_any |=> ifs_ff[`IFSL_BUF_HI:`IFSL_BUF_LO] == ($past(fa_parity_err) ? 2'h0 :
      ($past(sa_parity_err) || $past(sa_multihit_err)) ? 2'h2 : 2'h0))
    else $error("faulty buffer field wrong");

  error_priority_a: assert property (
    err_evt && fa_parity_err |=> ifs_ff[`IFSL_IDX_HI:`IFSL_IDX_LO] == $past(fa_parity_idx))
    else $error("full parity error not given priority");

  multihit_index_a: assert property (
    err_evt && sa_multihit_err && !fa_parity_err && !sa_parity_err
    |=> ifs_ff[`IFSL_IDX_HI:`IFSL_IDX_LO] == $past(sa_multihit_idx) && ifs_ff[`IFSL_MHIT] && !ifs_ff[`IFSL_PAR])
    else $error("multi-hit index or status wrong");

  marked_ue_a: assert property (
    err_evt && uncorrectable_fetch_error |=> ifs_ff[`IFSL_MK] && ifs_ff[`IFSL_UE])
    else $error("uncorrectable error not marked");

  mark_tag_a: assert property (
    err_evt && uncorrectable_fetch_error |=> ifs_ff[`IFSL_EID_HI:`IFSL_EID_LO] == $past(err_mark_tag))
    else $error("mark tag not captured");

  bus_reply_a: assert property (
    err_evt |=> ifs_ff[`IFSL_BUS_ERROR_REPLY] == $past(bus_error_reply) && ifs_ff[`IFSL_BUS_TIMEOUT_REPLY] == $past(bus_timeout_reply))
    else $error("bus reply bits wrong");

  noncache_a: assert property (
    err_evt |=> ifs_ff[`IFSL_NC] == $past(noncacheable))
    else $error("noncacheable bit wrong");

  space_code_a: assert property (
    upd_evt && trap_kind != ifsl_pkg::IFSL_KIND_MISS
    |=> ifs_ff[`IFSL_ASI_HI:`IFSL_ASI_LO] == (($past(trap_depth) == '0) ? 8'h80 : 8'h04))
    else $error("space id code wrong");

  miss_no_valid_a: assert property (
    trap_valid && trap_kind == ifsl_pkg::IFSL_KIND_MISS && !ifs_ff[`IFSL_FV] && !dp_wr_ff
    |=> !ifs_ff[`IFSL_FV] && ifs_ff[`IFSL_TM])
    else $error("miss set fault valid");

  overwrite_flag_a: assert property (
    upd_evt && trap_kind != ifsl_pkg::IFSL_KIND_MISS && ifs_ff[`IFSL_FV] && !dp_wr_ff
    |=> ifs_ff[`IFSL_OW] && ists_ff[`IFSL_IRQ_OVW])
    else $error("overwrite flag not set");

  hold_idle_a: assert property (
    !trap_valid && !dp_wr_ff |=> $stable(ifs_ff))
    else $error("status changed without a trap");

  reserved_zero_a: assert property (
    (ifs_ff & ~`IFSL_IFS_RW_MASK) == 64'h0000_0000_0000_0000)
    else $error("reserved bits not zero");

  cover_err_ue_c: cover property (err_evt && uncorrectable_fetch_error ##1 irq_ff);
  cover_overwrite_c: cover property (err_evt ##[1:20] err_evt && ifs_ff[`IFSL_FV]);
  cover_all_tlb_c: cover property (err_evt && fa_parity_err && sa_parity_err && sa_multihit_err && fa_multihit_err);
  cover_miss_c: cover property (trap_valid && trap_kind == ifsl_pkg::IFSL_KIND_MISS);

endmodule : ifsl_top

/* File: common/ifsl_defines.svh */
// register offsets, field positions, reset values and codes of the fault status logger
`ifndef IFSL_DEFINES_SVH
`define IFSL_DEFINES_SVH

`define IFSL_OFS_IFS_LO 8'h00
`define IFSL_OFS_IFS_HI 8'h04
`define IFSL_OFS_DFS_LO 8'h08
`define IFSL_OFS_DFS_HI 8'h0C
`define IFSL_OFS_IRQ_STAT 8'h10
`define IFSL_OFS_IRQ_MASK 8'h14

`define IFSL_BUF_HI 63
`define IFSL_BUF_LO 62
`define IFSL_IDX_HI 59
`define IFSL_IDX_LO 49
`define IFSL_MK 46
`define IFSL_EID_HI 45
`define IFSL_EID_LO 32
`define IFSL_UE 31
`define IFSL_BUS_ERROR_REPLY 30
`define IFSL_BUS_TIMEOUT_REPLY 29
`define IFSL_MHIT 27
`define IFSL_PAR 26
`define IFSL_NC 25
`define IFSL_ASI_HI 23
`define IFSL_ASI_LO 16
`define IFSL_TM 15
`define IFSL_OW 1
`define IFSL_FV 0

`define IFSL_IFS_RW_MASK 64'hCFFE_7FFF_EFFF_FFFF
`define IFSL_IFS_RESET 64'h0000_0000_0000_0000
`define IFSL_DFS_RESET 64'h0000_0000_0000_0000
`define IFSL_IRQ_RESET 4'h0

`define IFSL_PRIMARY_SPACE_CODE 8'h80
`define IFSL_NUCLEUS_SPACE_CODE 8'h04

`define IFSL_IRQ_MISS 0
`define IFSL_IRQ_EXC 1
`define IFSL_IRQ_ERR 2
`define IFSL_IRQ_OVW 3

`endif

/* File: common/ifsl_pkg.sv */
// types shared by the fault status logger files
package ifsl_pkg;

  typedef enum logic [1:0] {
    IFSL_KIND_NONE = 2'b00,
    IFSL_KIND_MISS = 2'b01,
    IFSL_KIND_EXC = 2'b10,
    IFSL_KIND_ERR = 2'b11
  } ifsl_kind_t;

  typedef enum logic [1:0] {
    IFSL_BUF_FULL = 2'b00,
    IFSL_BUF_SET = 2'b10
  } ifsl_buf_t;

  typedef enum logic [2:0] {
    IFSL_REG_IFS_LO = 3'b000,
    IFSL_REG_IFS_HI = 3'b001,
    IFSL_REG_DFS_LO = 3'b010,
    IFSL_REG_DFS_HI = 3'b011,
    IFSL_REG_IRQ_STAT = 3'b100,
    IFSL_REG_IRQ_MASK = 3'b101,
    IFSL_REG_NONE = 3'b111
  } ifsl_reg_t;

endpackage : ifsl_pkg

/* File: hw/ifsl_tlb_pick.sv */
// priority pick among concurrent translation buffer errors
`timescale 1ns/10ps
module ifsl_tlb_pick #(
  parameter int IDX_W = 11
) (
  input wire logic fa_parity_err,
  input wire logic sa_parity_err,
  input wire logic sa_multihit_err,
  input wire logic fa_multihit_err,
  input wire logic [IDX_W-1:0] fa_parity_idx,
  input wire logic [IDX_W-1:0] sa_parity_idx,
  input wire logic [IDX_W-1:0] sa_multihit_idx,
  input wire logic [IDX_W-1:0] fa_multihit_idx,
  output logic any_err,
  output ifsl_pkg::ifsl_buf_t buf_sel,
  output logic [IDX_W-1:0] idx,
  output logic multihit,
  output logic parity
);

  logic [3:0] err_vec;
  logic [IDX_W-1:0] idx_vec [4];
  ifsl_pkg::ifsl_buf_t buf_vec [4];

  // slot 0 is the highest priority
  assign err_vec = {fa_multihit_err, sa_multihit_err, sa_parity_err, fa_parity_err};
  assign idx_vec[0] = fa_parity_idx;
  assign idx_vec[1] = sa_parity_idx;
  assign idx_vec[2] = sa_multihit_idx;
  assign idx_vec[3] = fa_multihit_idx;
  assign buf_vec[0] = ifsl_pkg::IFSL_BUF_FULL;
  assign buf_vec[1] = ifsl_pkg::IFSL_BUF_SET;
  assign buf_vec[2] = ifsl_pkg::IFSL_BUF_SET;
  assign buf_vec[3] = ifsl_pkg::IFSL_BUF_FULL;

  always_comb begin
    any_err = 1'b0;
    buf_sel = ifsl_pkg::IFSL_BUF_FULL;
    idx = '0;
    multihit = 1'b0;
    parity = 1'b0;
    // walk from lowest to highest so the highest present wins
    for (int i = 3; i >= 0; i--) begin
      if (err_vec[i]) begin
        any_err = 1'b1;
        buf_sel = buf_vec[i];
        idx = idx_vec[i];
        multihit = (i >= 2);
        parity = (i < 2);
      end
    end
  end

endmodule : ifsl_tlb_pick

/* File: testbench/ifsl_fetch_partner.sv */
// behavioural far side: lookup, fetch path and trap logic
`timescale 1ns/10ps
module ifsl_fetch_partner #(
  parameter logic [43:0] IDX_SET = 44'h0
) (
  input wire logic hclk,
  output logic trap_valid,
  output ifsl_pkg::ifsl_kind_t trap_kind,
  output logic [2:0] trap_depth,
  output logic [3:0] lk_err,
  output logic [43:0] lk_idx,
  output logic [3:0] det,
  output logic [13:0] tag
);
  initial begin
    trap_valid = 1'b0;
    trap_kind = ifsl_pkg::IFSL_KIND_NONE;
    trap_depth = 3'h0;
    lk_err = 4'h0;
    lk_idx = 44'h0;
    det = 4'h0;
    tag = 14'h0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // one-cycle pulse; details scrambled afterwards so stale values never help
  task automatic fire(input ifsl_pkg::ifsl_kind_t k, input logic [2:0] d, input logic [3:0] e,
                      input logic [3:0] x, input logic [13:0] t);
    trap_valid <= 1'b1;
    trap_kind <= k;
    trap_depth <= d;
    lk_err <= e;
    lk_idx <= IDX_SET;
    det <= x;
    tag <= t;
    @(posedge hclk);
    trap_valid <= 1'b0;
    trap_kind <= ifsl_pkg::ifsl_kind_t'(~k);
    trap_depth <= ~d;
    lk_err <= ~e;
    lk_idx <= ~IDX_SET;
    det <= ~x;
    tag <= ~t;
  endtask : fire
endmodule : ifsl_fetch_partner

/* File: testbench/test_instr_fault_status_logger.sv */
// self-checking bench for the instruction fault status logger
`timescale 1ns/10ps
`include "ifsl_defines.svh"
module test_instr_fault_status_logger;
  localparam logic [43:0] IDXS = {11'h7FF, 11'h400, 11'h001, 11'h2AA};
  localparam logic [63:0] RSV = (64'h3 << 60) | (64'h3 << 47) | (64'h1 << 28);
  logic hclk;
  logic hresetn;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic hready;
  logic [31:0] hrdata;
  logic hresp;
  logic irq;
  logic trap_valid;
  ifsl_pkg::ifsl_kind_t trap_kind;
  logic [2:0] trap_depth;
  logic [3:0] lk_err;
  logic [43:0] lk_idx;
  logic [3:0] det;
  logic [13:0] tag;
  int err_total;
  int samples_checked;

  ifsl_top dut_u (
    .hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
    .hready, .hrdata, .hreadyout(hready), .hresp, .irq, .trap_valid, .trap_kind, .trap_depth,
    .fa_parity_err(lk_err[3]), .sa_parity_err(lk_err[2]), .sa_multihit_err(lk_err[1]),
    .fa_multihit_err(lk_err[0]), .fa_parity_idx(lk_idx[43:33]), .sa_parity_idx(lk_idx[32:22]),
    .sa_multihit_idx(lk_idx[21:11]), .fa_multihit_idx(lk_idx[10:0]),
    .uncorrectable_fetch_error(det[3]), .err_mark_tag(tag), .bus_error_reply(det[2]),
    .bus_timeout_reply(det[1]), .noncacheable(det[0])
  );

  ifsl_fetch_partner #(.IDX_SET(IDXS)) partner_u (
    .hclk, .trap_valid, .trap_kind, .trap_depth, .lk_err, .lk_idx, .det, .tag
  );

  //////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (err_total == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input logic [63:0] m);
    samples_checked++;
    if ((got & m) !== (exp & m)) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h mask %h", $time, got, exp, m);
    end
  endtask : chk

  // never trust a fixed latency: poll hready under a bound
  task automatic edge_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    if (hready !== 1'b1) begin
      err_total++;
      $display("[ERR] %0t bus wait ran out", $time);
      conclude();
    end
  endtask : edge_ready

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    edge_ready();
    htrans <= 2'b00;
    hwdata <= wd;
    edge_ready();
    rd = hrdata;
    chk({63'h0, hresp}, 64'h0, 64'h1);
  endtask : xfer

  task automatic rd64(output logic [63:0] v);
    xfer(1'b0, `IFSL_OFS_IFS_LO, 32'h0, v[31:0]);
    xfer(1'b0, `IFSL_OFS_IFS_HI, 32'h0, v[63:32]);
  endtask : rd64

  task automatic wr64(input logic [63:0] v);
    logic [31:0] r;
    xfer(1'b1, `IFSL_OFS_IFS_LO, v[31:0], r);
    xfer(1'b1, `IFSL_OFS_IFS_HI, v[63:32], r);
  endtask : wr64

  // irq is registered: sample mid-cycle, resume on a rising edge
  task automatic irq_is(input logic e);
    @(posedge hclk);
    @(negedge hclk);
    chk({63'h0, irq}, {63'h0, e}, 64'h1);
    @(posedge hclk);
  endtask : irq_is

  //////////////////////////////////////////////////////////////////////////////
  task automatic s_reset();
    logic [63:0] v;
    logic [31:0] r;
    rd64(v);
    chk(v, 64'h0, '1);
    xfer(1'b1, 8'h40, 32'hFFFF_FFFF, r);
    xfer(1'b0, 8'h40, 32'h0, r);
    chk({32'h0, r}, 64'h0, '1);
    wr64('1);
    rd64(v);
    chk(v, ~RSV, '1);
    wr64(64'h0);
    rd64(v);
    chk(v, 64'h0, '1);
    // data side word is plain storage, halves written independently
    xfer(1'b1, `IFSL_OFS_DFS_LO, 32'hA5A5_5A5A, r);
    xfer(1'b1, `IFSL_OFS_DFS_HI, 32'h0F0F_F0F0, r);
    xfer(1'b0, `IFSL_OFS_DFS_LO, 32'h0, r);
    chk({32'h0, r}, 64'hA5A5_5A5A, '1);
    xfer(1'b0, `IFSL_OFS_DFS_HI, 32'h0, r);
    chk({32'h0, r}, 64'h0F0F_F0F0, '1);
    // mask left fully open so later error traps raise irq
    xfer(1'b1, `IFSL_OFS_IRQ_MASK, 32'hFFFF_FFFF, r);
    xfer(1'b0, `IFSL_OFS_IRQ_MASK, 32'h0, r);
    chk({32'h0, r}, 64'hF, '1);
  endtask : s_reset

  task automatic s_prio();
    logic [63:0] v, e, m;
    logic [3:0] sel;
    for (int k = 0; k < 4; k++) begin
      sel = 4'hF >> k;
      wr64(64'h0);
      partner_u.fire(ifsl_pkg::IFSL_KIND_ERR, 3'h0, sel, 4'h0, 14'h0);
      rd64(v);
      e = 64'h1;
      m = 64'h1 | (64'h3 << 62) | (64'h7FF << 49) | (64'h3 << 26);
      e[63:62] = (k == 1 || k == 2) ? 2'b10 : 2'b00;
      e[59:49] = IDXS[43 - 11 * k -: 11];
      e[26] = (k < 2);
      e[27] = (k > 1);
      chk(v, e, m);
    end
  endtask : s_prio

  task automatic s_err();
    logic [63:0] v;
    logic [31:0] r;
    wr64(64'h0);
    xfer(1'b1, `IFSL_OFS_IRQ_STAT, 32'hF, r);
    partner_u.fire(ifsl_pkg::IFSL_KIND_ERR, 3'h0, 4'h0, 4'hF, 14'h2A5C);
    rd64(v);
    chk(v, 64'h0000_6A5C_E280_0001, 64'h0000_7FFF_EEFF_0003);
    partner_u.fire(ifsl_pkg::IFSL_KIND_ERR, 3'h1, 4'h0, 4'h0, 14'h1111);
    rd64(v);
    chk(v, 64'h0000_0000_0004_0003, 64'h0000_4000_EEFF_0003);
    xfer(1'b0, `IFSL_OFS_IRQ_STAT, 32'h0, r);
    chk({32'h0, r}, 64'hC, 64'hF);
  endtask : s_err

  task automatic s_miss();
    logic [63:0] v;
    wr64(64'h0);
    partner_u.fire(ifsl_pkg::IFSL_KIND_NONE, 3'h0, 4'hF, 4'hF, 14'h3FFF);
    rd64(v);
    chk(v, 64'h0, '1);
    partner_u.fire(ifsl_pkg::IFSL_KIND_MISS, 3'h0, 4'h0, 4'h0, 14'h0);
    rd64(v);
    chk(v, 64'h8000, 64'h8003);
    partner_u.fire(ifsl_pkg::IFSL_KIND_EXC, 3'h7, 4'h0, 4'h0, 14'h0);
    rd64(v);
    chk(v, 64'h0004_0001, 64'hFF_8003);
  endtask : s_miss

  task automatic s_irq();
    logic [31:0] r;
    xfer(1'b1, `IFSL_OFS_IRQ_MASK, 32'h0, r);
    xfer(1'b1, `IFSL_OFS_IRQ_STAT, 32'hF, r);
    partner_u.fire(ifsl_pkg::IFSL_KIND_MISS, 3'h0, 4'h0, 4'h0, 14'h0);
    irq_is(1'b0);
    xfer(1'b0, `IFSL_OFS_IRQ_STAT, 32'h0, r);
    chk({32'h0, r}, 64'h1, 64'hF);
    xfer(1'b1, `IFSL_OFS_IRQ_MASK, 32'h1, r);
    irq_is(1'b1);
    xfer(1'b1, `IFSL_OFS_IRQ_STAT, 32'h1, r);
    irq_is(1'b0);
    xfer(1'b0, `IFSL_OFS_IRQ_STAT, 32'h0, r);
    chk({32'h0, r}, 64'h0, 64'hF);
  endtask : s_irq

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  initial begin
    err_total = 0;
    samples_checked = 0;
    hresetn = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    s_reset();
    s_prio();
    s_err();
    s_miss();
    s_irq();
    conclude();
  end
endmodule : test_instr_fault_status_logger
